// [ea_pkg.sv]
// Package: constants and types for the effective address generator
// Assumes: included before the interface and the design modules
package ea_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int PORT_W = 16;
    localparam int REG_SEL_W = 3;
    // ------------------------------------------------------------
    // Register selector codes
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_STACK_PTR = 3'h4;
    localparam logic [2:0] SEL_FRAME_PTR = 3'h5;
    // ------------------------------------------------------------
    // Boundaries
    // ------------------------------------------------------------
    localparam logic [3:0] DQ_ALIGN_MASK = 4'hf;
    localparam int LANE_SMALL = 4;
    localparam int LANE_QUAD = 8;
    localparam int DQ_BYTES = 16;
    localparam logic [15:0] OFFS16_MASK = 16'hffff;

    typedef enum logic [1:0] {
        DISP_NONE,
        DISP_8,
        DISP_16,
        DISP_32
    } disp_size_t;

    typedef enum logic [1:0] {
        SCALE_1,
        SCALE_2,
        SCALE_4,
        SCALE_8
    } scale_t;

    typedef enum logic [2:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_DWORD,
        SIZE_QWORD,
        SIZE_DQWORD
    } op_size_t;

    typedef enum logic {
        SEG_DATA,
        SEG_STACK
    } segment_t;

    typedef enum logic {
        IDLE,
        SECOND
    } split_state_t;
endpackage

// [ea_sum_if.sv]
// Interface: offset components passed to the sum stage
// Assumes: one clock domain, driven by the top module
`timescale 1ns/100ps
interface ea_sum_if;
    import ea_pkg::*;
    logic [ADDR_W-1:0] disp;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] index;
    logic base_en;
    logic index_en;
    scale_t scale;
    logic addr16;
    logic [ADDR_W-1:0] offset;
    modport src (output disp, base, index, base_en, index_en, scale,
        addr16, input offset);
    modport sum (input disp, base, index, base_en, index_en, scale,
        addr16, output offset);
endinterface

// [ea_sum.sv]
// Offset adder: displacement + base + scaled index
// Assumes: components already sign-extended to the address width
`timescale 1ns/100ps
module ea_sum
    import ea_pkg::*;
(
    ea_sum_if.sum s // Component and result bundle
);
    wire [ADDR_W-1:0] base_term;
    wire [ADDR_W-1:0] index_term;
    wire [ADDR_W-1:0] full_sum;

    assign base_term = s.base_en ? s.base : '0; // [RULE1]
    // Scale is an unsigned shift of a signed index
    assign index_term = s.index_en ?
        (s.index << s.scale) : '0; // [RULE3] [RULE4] [RULE7]
    assign full_sum = s.disp + base_term + index_term; // [RULE1] [RULE4]
    // Carries past the top offset bit are dropped
    assign s.offset = s.addr16 ?
        {16'h0000, full_sum[15:0] & OFFS16_MASK} : full_sum; // [RULE17]
endmodule

// [ea_gen.sv]
// Effective address and I/O port address generator
// Assumes: decode logic presents one request per cycle, synchronous to clk
//
// Behaviour
// RULE1 - Offset is sum of present displacement, base and scaled index.
// RULE2 - Displacement may be 8, 16 or 32 bits wide.
// RULE3 - Index is multiplied by scale 2, 4 or 8.
// RULE4 - Components are signed two's complement; scale is unsigned.
// RULE5 - Stack pointer is never used as scaled index.
// RULE6 - Stack or frame pointer base selects stack segment, else data.
// RULE7 - Scale applies only when an index is present.
// RULE8 - I/O space of 65,536 byte ports; wider ports allowed.
// RULE9 - Port number from immediate or port select register.
// RULE10 - Sizes byte, word, dword, qword, dqword supported.
// RULE11 - Little-endian: low byte at the operand address.
// RULE12 - Word, dword, qword accepted at any address without fault.
// RULE13 - Crossing 4- or 8-byte boundary needs two bus cycles.
// RULE14 - Aligned-only dqword faults when address not divisible by 16.
// RULE15 - Unaligned-tolerant dqword completes with extra bus cycles.
// RULE16 - 16-bit address size uses 16-bit offsets and displacements.
// RULE17 - Summed address is truncated to the active address size.
`timescale 1ns/100ps
module ea_gen
    import ea_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, active high
    input wire logic req_valid, // Memory operand request
    output logic req_ready, // Generator idle, request can be taken this cycle
    input wire logic [ADDR_W-1:0] disp_in, // Raw displacement field
    input wire logic [1:0] disp_size, // disp_size_t encoding
    input wire logic base_en, // Base component present
    input wire logic [REG_SEL_W-1:0] base_sel, // Base register number
    input wire logic [ADDR_W-1:0] base_val, // Base register value
    input wire logic index_en, // Index component present
    input wire logic [REG_SEL_W-1:0] index_sel, // Index register number
    input wire logic [ADDR_W-1:0] index_val, // Index register value
    input wire logic [1:0] scale, // scale_t encoding
    input wire logic addr16, // 16-bit address size
    input wire logic [2:0] op_size, // op_size_t encoding
    input wire logic dq_align_req, // Dqword needs 16-byte alignment
    input wire logic io_valid, // I/O port address request
    input wire logic io_use_imm, // Port number from immediate
    input wire logic [7:0] io_imm, // Immediate port number
    input wire logic [PORT_W-1:0] io_port_select_reg, // Port select reg
    input wire logic [2:0] io_size, // Port width, op_size_t
    output logic bus_valid, // One memory bus cycle issued
    output logic [ADDR_W-1:0] bus_addr, // Bus cycle address
    output logic [4:0] bus_bytes, // Bytes in this bus cycle
    output logic bus_last, // Last bus cycle of the operand
    output logic stack_segment, // Stack segment selected
    output logic data_segment, // Data segment selected
    output logic [ADDR_W-1:0] eff_addr, // Effective address of operand
    output logic general_protection_fault, // Alignment fault pulse
    output logic io_out_valid, // Port address valid
    output logic [PORT_W-1:0] io_port, // Port address
    output logic [2:0] io_width // Port width, op_size_t
);
    // ------------------------------------------------------------
    // Component preparation
    // ------------------------------------------------------------
    ea_sum_if s();
    ea_sum u_sum (.s(s));

    wire [ADDR_W-1:0] disp_ext;
    wire index_ok;
    disp_size_t dsize;
    assign dsize = disp_size_t'(disp_size);
    assign disp_ext = (dsize == DISP_8) ? {{24{disp_in[7]}}, disp_in[7:0]} :
        (dsize == DISP_16) ? {{16{disp_in[15]}}, disp_in[15:0]} :
        (dsize == DISP_32) ? disp_in : '0; // [RULE2] [RULE4] [RULE16]
    // Stack pointer encoding means no index
    assign index_ok = index_en && (index_sel != SEL_STACK_PTR); // [RULE5]

    assign s.disp = disp_ext;
    assign s.base = base_val;
    assign s.index = index_val;
    assign s.base_en = base_en;
    assign s.index_en = index_ok; // [RULE7]
    assign s.scale = scale_t'(scale);
    assign s.addr16 = addr16; // [RULE16]

    wire use_stack;
    assign use_stack = base_en && ((base_sel == SEL_STACK_PTR) ||
        (base_sel == SEL_FRAME_PTR)); // [RULE6]

    // ------------------------------------------------------------
    // Alignment and split decision
    // ------------------------------------------------------------
    wire [ADDR_W-1:0] offs;
    wire [4:0] nbytes;
    wire [3:0] lane;
    wire crosses;
    wire dq_fault;
    wire [4:0] first_bytes;
    op_size_t osize;
    assign offs = s.offset;
    assign osize = op_size_t'(op_size);
    assign nbytes = (osize == SIZE_BYTE) ? 5'h01 :
        (osize == SIZE_WORD) ? 5'h02 :
        (osize == SIZE_DWORD) ? 5'h04 :
        (osize == SIZE_QWORD) ? 5'h08 : 5'h10; // [RULE10]
    // Byte lane width: 4 for word/dword, 8 for qword and dqword
    assign lane = (osize == SIZE_QWORD || osize == SIZE_DQWORD) ?
        4'(LANE_QUAD) : 4'(LANE_SMALL);
    wire [4:0] lane_pos;
    assign lane_pos = (lane == 4'(LANE_QUAD)) ? {2'b00, offs[2:0]} :
        {3'b000, offs[1:0]};
    // Dqword spans two qword lanes when aligned; treat by 16-byte mask
    assign crosses = (osize == SIZE_DQWORD) ? (offs[3:0] != 4'h0) :
        ((lane_pos + nbytes) > {1'b0, lane}); // [RULE12] [RULE13] [RULE15]
    assign dq_fault = (osize == SIZE_DQWORD) && dq_align_req &&
        ((offs[3:0] & DQ_ALIGN_MASK) != 4'h0); // [RULE14]
    // First cycle covers the bytes up to the boundary
    assign first_bytes = (osize == SIZE_DQWORD) ?
        (5'(DQ_BYTES) - {1'b0, offs[3:0]}) :
        ({1'b0, lane} - lane_pos);

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    split_state_t state;
    logic [ADDR_W-1:0] rest_addr;
    logic [4:0] rest_bytes;
    wire take;
    wire [ADDR_W-1:0] rest_sum;
    assign req_ready = (state == IDLE);
    assign take = req_valid && req_ready;
    assign rest_sum = offs + ADDR_W'(first_bytes);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= IDLE;
            rest_addr <= '0;
            rest_bytes <= '0;
        end else if (state == SECOND) begin
            state <= IDLE;
        end else if (take && crosses && !dq_fault) begin
            state <= SECOND; // [RULE13] [RULE15]
            rest_addr <= addr16 ? {16'h0000, rest_sum[15:0]} : rest_sum;
            rest_bytes <= nbytes - first_bytes;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_valid <= 1'b0;
            bus_addr <= '0;
            bus_bytes <= '0;
            bus_last <= 1'b0;
            eff_addr <= '0;
            stack_segment <= 1'b0;
            data_segment <= 1'b0;
            general_protection_fault <= 1'b0;
        end else if (state == SECOND) begin
            bus_valid <= 1'b1;
            bus_addr <= rest_addr;
            bus_bytes <= rest_bytes;
            bus_last <= 1'b1;
            general_protection_fault <= 1'b0;
        end else begin
            // Operand address is its low byte address
            bus_valid <= take && !dq_fault; // [RULE11]
            bus_addr <= offs; // [RULE11]
            bus_bytes <= crosses ? first_bytes : nbytes;
            bus_last <= !crosses;
            general_protection_fault <= take && dq_fault; // [RULE14]
            if (take) begin
                eff_addr <= offs; // [RULE1] [RULE17]
                stack_segment <= use_stack; // [RULE6]
                data_segment <= !use_stack; // [RULE6]
            end
        end
    end

    // ------------------------------------------------------------
    // I/O port address
    // ------------------------------------------------------------
    wire [PORT_W-1:0] next_io_port;
    assign next_io_port = io_use_imm ? {8'h00, io_imm} :
        io_port_select_reg; // [RULE9]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_out_valid <= 1'b0;
            io_port <= '0;
            io_width <= 3'h0;
        end else begin
            io_out_valid <= io_valid; // [RULE8]
            if (io_valid) begin
                io_port <= next_io_port; // [RULE8]
                io_width <= io_size; // [RULE8]
            end
        end
    end
endmodule

// [ea_gen_checker.sv]
// Checker: port-level timing and value properties of ea_gen
// Assumes: bound to every ea_gen instance, one clock domain
`timescale 1ns/100ps
module ea_gen_checker
    import ea_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic req_valid, // Request
    input wire logic req_ready, // Ready
    input wire logic base_en, // Base present
    input wire logic [REG_SEL_W-1:0] base_sel, // Base number
    input wire logic addr16, // Short mode
    input wire logic [2:0] op_size, // Size
    input wire logic dq_align_req, // Align demand
    input wire logic io_valid, // Port request
    input wire logic io_use_imm, // Immediate port
    input wire logic [7:0] io_imm, // Port number
    input wire logic [PORT_W-1:0] io_port_select_reg, // Port reg
    input wire logic bus_valid, // Bus cycle
    input wire logic [ADDR_W-1:0] bus_addr, // Bus address
    input wire logic [4:0] bus_bytes, // Bus bytes
    input wire logic bus_last, // Last cycle
    input wire logic stack_segment, // Stack seg
    input wire logic data_segment, // Data seg
    input wire logic [ADDR_W-1:0] eff_addr, // Offset
    input wire logic general_protection_fault, // Fault
    input wire logic io_out_valid, // Port valid
    input wire logic [PORT_W-1:0] io_port // Port out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire take = req_valid && req_ready;
    wire stk = base_en && (base_sel == SEL_STACK_PTR ||
        base_sel == SEL_FRAME_PTR);
    a_seg_stack: assert property (
        take && stk |=> stack_segment && !data_segment)
        else $error("stack segment not chosen");
    a_seg_data: assert property (
        take && !stk |=> data_segment && !stack_segment)
        else $error("data segment not chosen");
    a_io_imm: assert property (
        io_valid && io_use_imm |=>
        io_out_valid && io_port == {8'h00, $past(io_imm)})
        else $error("immediate port wrong");
    a_io_reg: assert property (
        io_valid && !io_use_imm |=>
        io_out_valid && io_port == $past(io_port_select_reg))
        else $error("register port wrong");
    a_dq_fault: assert property (
        take && op_size == 3'h4 && dq_align_req |=>
        general_protection_fault == (eff_addr[3:0] != 4'h0) &&
        bus_valid != general_protection_fault)
        else $error("alignment fault wrong");
    a_small_nofault: assert property (
        take && op_size < 3'h4 |=> !general_protection_fault && bus_valid)
        else $error("small operand faulted");
    // Second half wraps inside 64 KBytes in short mode
    a_split_pair: assert property (
        bus_valid && !bus_last |=> bus_valid && bus_last &&
        bus_addr == ($past(addr16, 2) ?
        32'(16'($past(bus_addr) + 32'($past(bus_bytes)))) :
        $past(bus_addr) + 32'($past(bus_bytes))))
        else $error("split second half wrong");
    a_split_stall: assert property (
        bus_valid && !bus_last |-> !req_ready)
        else $error("request accepted during split");
    a_first_addr: assert property (
        take ##1 bus_valid |-> bus_addr == eff_addr)
        else $error("first cycle not at low byte");
    a_addr_short: assert property (
        take && addr16 |=> eff_addr[31:16] == 16'h0000)
        else $error("short offset too wide");
    c_split: cover property (bus_valid && !bus_last);
    c_fault: cover property (general_protection_fault);
    c_stack: cover property (take && stk);
endmodule
bind ea_gen ea_gen_checker chk (.clk, .rst, .req_valid, .req_ready,
    .base_en, .base_sel, .addr16, .op_size, .dq_align_req, .io_valid,
    .io_use_imm, .io_imm, .io_port_select_reg, .bus_valid, .bus_addr,
    .bus_bytes, .bus_last, .stack_segment, .data_segment, .eff_addr,
    .general_protection_fault, .io_out_valid, .io_port);

// [ea_decode_model.sv]
// Partner: decode stage presenting memory requests to ea_gen
// Assumes: caller sets operand fields at a falling edge, then calls send
`timescale 1ns/100ps
module ea_decode_model (
    input wire logic clk, // Core clock
    input wire logic req_ready, // Generator ready
    output logic req_valid // Request to generator
);
    initial req_valid = 1'b0;
    // Hold request until a rising edge sees ready
    task automatic send;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
    endtask
endmodule

// [effective_address_generation_test.sv]
// Testbench: ea_gen against a reference model of offsets and bus cycles
// Assumes: ea_decode_model as requester, checker bound separately
`timescale 1ns/100ps
module effective_address_generation_test;
    import ea_pkg::*;
    logic clk = 0, rst = 1, req_valid, req_ready, base_en, index_en;
    logic addr16, dq_align_req, io_valid = 0, io_use_imm, bus_valid;
    logic bus_last, stack_segment, data_segment, general_protection_fault;
    logic io_out_valid;
    logic [1:0] disp_size, scale;
    logic [2:0] base_sel, index_sel, op_size, io_size, io_width;
    logic [31:0] disp_in, base_val, index_val, bus_addr, eff_addr;
    logic [7:0] io_imm;
    logic [15:0] io_port_select_reg, io_port;
    logic [4:0] bus_bytes;
    int mismatches = 0, checked = 0;
    always #12.5 clk = ~clk;
    ea_gen uut (
        .clk, .rst, .req_valid, .req_ready, .disp_in, .disp_size,
        .base_en, .base_sel, .base_val, .index_en, .index_sel,
        .index_val, .scale, .addr16, .op_size, .dq_align_req,
        .io_valid, .io_use_imm, .io_imm, .io_port_select_reg, .io_size,
        .bus_valid, .bus_addr, .bus_bytes, .bus_last, .stack_segment,
        .data_segment, .eff_addr, .general_protection_fault,
        .io_out_valid, .io_port, .io_width
    );
    ea_decode_model dec (.clk, .req_ready, .req_valid);
    task automatic chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------
    // One memory operand, checked against the model
    // ------------------------------------------------------------
    task automatic mem(input logic [31:0] d, b, x, input logic [1:0] ds, sc,
        input logic [2:0] bs, xs, os, input logic be, xe, a16, al);
        logic [31:0] v;
        int n, lane, f;
        bit split, fault;
        @(negedge clk);
        {disp_in, base_val, index_val, disp_size, scale} = {d, b, x, ds, sc};
        {base_sel, index_sel, op_size} = {bs, xs, os};
        {base_en, index_en} = {be, xe};
        {addr16, dq_align_req} = {a16, al};
        dec.send();
        {disp_in, base_val, index_val} = {~d, ~b, ~x};
        v = ds == 1 ? {{24{d[7]}}, d[7:0]} : ds == 2 ? {{16{d[15]}}, d[15:0]}
            : ds == 3 ? d : 0;
        if (be) v += b;
        if (xe && xs != SEL_STACK_PTR) v += x << sc;
        if (a16) v &= 32'h0000ffff;
        n = 1 << os;
        lane = os == 3 ? LANE_QUAD : os == 4 ? DQ_BYTES : LANE_SMALL;
        split = os != 0 && (v % lane) + n > lane;
        f = split ? lane - v % lane : n;
        fault = os == 4 && al && v[3:0] != 4'h0;
        chk(eff_addr, v);
        chk(stack_segment, be && (bs == 4 || bs == 5));
        chk(data_segment, !(be && (bs == 4 || bs == 5)));
        chk(req_ready, fault || !split);
        chk(general_protection_fault, fault);
        chk(bus_valid, !fault);
        if (!fault) begin
            chk(bus_addr, v);
            chk(bus_bytes, f);
            chk(bus_last, !split);
        end
        if (!fault && split) begin
            @(negedge clk);
            chk(bus_valid && bus_last, 1);
            chk(bus_addr, a16 ? (v + f) & 32'hffff : v + f);
            chk(bus_bytes, n - f);
        end
    endtask
    initial begin
        #1000000;
        mismatches++;
        complete_run();
    end
    initial begin
        {disp_in, base_val, index_val, disp_size, scale} = 0;
        {base_sel, index_sel, op_size, base_en, index_en} = 0;
        {addr16, dq_align_req, io_use_imm, io_imm} = 0;
        {io_port_select_reg, io_size} = 0;
        void'($urandom(56408));
        repeat (10) @(negedge clk);
        rst = 0;
        mem(6, 0, 0, 3, 0, 0, 0, 2, 0, 0, 0, 0);
        mem(32'hf0, 32'h100, 0, 1, 0, 5, 0, 1, 1, 0, 0, 0);
        mem(0, 32'h20, 32'h40, 0, 3, 0, 4, 2, 1, 1, 0, 0);
        mem(0, 0, 3, 0, 3, 0, 1, 3, 0, 1, 0, 0);
        mem(32'h13, 0, 0, 3, 0, 0, 0, 4, 0, 0, 0, 1);
        mem(32'h13, 0, 0, 3, 0, 0, 0, 4, 0, 0, 0, 0);
        mem(2, 32'hffff, 0, 1, 0, 3, 0, 2, 1, 0, 1, 0);
        mem(32'h8000, 0, 0, 2, 0, 0, 0, 0, 0, 0, 0, 0);
        $display("directed memory test done");
        repeat (400) mem($urandom, $urandom, $urandom, $urandom, $urandom,
            $urandom, $urandom, $urandom % 5, $urandom, $urandom,
            $urandom, $urandom);
        $display("random memory test done");
        @(negedge clk);
        repeat (40) begin
            {io_valid, io_use_imm} = {1'b1, 1'($urandom)};
            io_imm = 8'($urandom);
            io_port_select_reg = 16'($urandom);
            io_size = 3'($urandom % 3);
            @(negedge clk);
            chk(io_out_valid, 1);
            chk(io_port, io_use_imm ? {8'h00, io_imm} :
                io_port_select_reg);
            chk(io_width, io_size);
        end
        io_valid = 0;
        $display("port address test done");
        complete_run();
    end
endmodule
